// ==== include/selftest_pkg.sv ====
package selftest_pkg;

  // ==========================================================================
  // Command codes
  // ==========================================================================
  typedef enum logic [3:0] {
    cmd_selftest      = 4'h0,
    cmd_wait          = 4'h1,
    cmd_opc_query     = 4'h2,
    cmd_card_clear    = 4'h3,
    cmd_card_exec     = 4'h4,
    cmd_card_state    = 4'h5,
    cmd_frame_clear   = 4'h6,
    cmd_frame_exec    = 4'h7,
    cmd_frame_state   = 4'h8,
    cmd_route_open    = 4'h9,
    cmd_route_close   = 4'ha
  } command_type;

  // ==========================================================================
  // Result encodings, card and frame selectors
  // ==========================================================================
  localparam logic [1:0] RES_PASS       = 2'h0;
  localparam logic [1:0] RES_FAIL       = 2'h1;
  localparam logic [1:0] RES_UNTESTED   = 2'h3;
  localparam int         NUM_CARDS      = 4;
  localparam logic [2:0] CARD_ALL       = 3'h0;
  localparam logic [2:0] CARD_MAX       = 3'h4;
  localparam logic       FRAME_CTRL     = 1'h0;
  localparam logic       FRAME_FRONT_PANEL_SELFTEST   = 1'h1;
  localparam logic [7:0] OPC_CHAR       = 8'h31;
  localparam int         CHAN_BITS      = 8;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ           = 125000000;
  localparam int KEY_TIMEOUT_S    = 10;
  localparam int KEY_TIMEOUT_CYC  = KEY_TIMEOUT_S * CLK_HZ;

endpackage : selftest_pkg

// ==== rtl/selftest_key_timer.sv ====
`timescale 1ns/1ps
module selftest_key_timer
  import selftest_pkg::*;
#(
  parameter int TIMEOUT_CYC = selftest_pkg::KEY_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic start,
  input  wire logic key_seen,
  // Outcome
  output logic      done,
  output logic      fail
);
  import selftest_pkg::*;

  // ==========================================================================
  // Key wait with timeout
  // ==========================================================================
  logic        running;
  logic [31:0] count;
  wire         expired = running && (count == 32'(TIMEOUT_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      running <= 1'b0;
      count   <= 32'h0;
      done    <= 1'b0;
      fail    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        running <= 1'b1;
        count   <= 32'h0;
      end else if (running && key_seen) begin
        running <= 1'b0;
        done    <= 1'b1;
        fail    <= 1'b0;
      end else if (expired) begin
        running <= 1'b0;
        done    <= 1'b1;
        fail    <= 1'b1;
      end else if (running) begin
        count <= count + 32'h1;
      end
    end
  end

  a_timeout_fail : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    expired && !key_seen && !start |=> done && fail)
    else $error("Key timeout did not report fail");

endmodule : selftest_key_timer

// ==== rtl/selftest_result_store.sv ====
`timescale 1ns/1ps
module selftest_result_store
  import selftest_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Update port
  input  wire logic       clear,
  input  wire logic       write,
  input  wire logic       write_fail,
  // Stored result
  output logic [1:0]      result
);
  import selftest_pkg::*;

  // ==========================================================================
  // One result cell, untested after reset or after a clear without write (write wins over clear)
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result <= RES_UNTESTED;
    end else if (write) begin
      result <= write_fail ? RES_FAIL : RES_PASS;
    end else if (clear) begin
      result <= RES_UNTESTED;
    end
  end

  a_clear_untested : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clear && !write |=> result == RES_UNTESTED)
    else $error("Cleared result not untested");

endmodule : selftest_result_store

// ==== rtl/self_test_command_handler.sv ====
// What this block does
// - Self-test query runs test, answers 0/1
// - After self-test, settings equal instrument reset
// - Wait command stalls until nothing pending
// - Diagnostics ignore config mode; cards 1-4/all
// - Card clear erases selected card results
// - Card execute answers 1 if any fail
// - Tested card gets power-on card settings
// - Card state query: 1 fail,0 pass,-1
// - Frame clear erases selected frame result
// - Frame execute runs test, answers 1/0
// - Controller test ends with instrument reset
// - Front-panel test leaves settings unchanged
// - Front-panel test fails without key in 10s
// - Frame state query: 1 fail,0 pass,-1
// - Open channel disconnects input from output
// - Close channel connects input to output
// - Completion query answers character 1
`timescale 1ns/1ps
module self_test_command_handler
  import selftest_pkg::*;
#(
  parameter int KEY_TIMEOUT = selftest_pkg::KEY_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  // Command port
  input  wire logic                      cmd_valid,
  output logic                           cmd_ready,
  input  wire selftest_pkg::command_type cmd_code,
  input  wire logic [2:0]                cmd_card,
  input  wire logic                      cmd_frame,
  input  wire logic [5:0]                cmd_channel,
  // Response port
  output logic                           rsp_valid,
  output logic [7:0]                     rsp_data,
  // Pending operation status
  input  wire logic                      op_pending,
  output logic                           operation_complete_flag,
  // Test engine
  output logic                           test_start,
  output logic [3:0]                     test_cards,
  output logic                           test_frame,
  output logic                           test_is_card,
  input  wire logic                      test_done,
  input  wire logic [3:0]                test_card_fail,
  input  wire logic                      test_frame_fail,
  // Front panel key (pin)
  input  wire logic                      key_press,
  // Settings actions
  output logic                           instrument_reset,
  output logic [3:0]                     power_on_card_settings,
  // Relay control
  output logic                           relay_strobe,
  output logic [2:0]                     relay_card,
  output logic [5:0]                     relay_channel,
  output logic                           relay_closed
);
  import selftest_pkg::*;

  // ==========================================================================
  // Card selector decode
  // ==========================================================================
  function automatic logic [3:0] card_mask(input logic [2:0] sel);
    if (sel == CARD_ALL) return 4'hf;
    else if (sel <= CARD_MAX) return 4'(4'h1 << (sel - 3'h1));
    else return 4'h0;
  endfunction : card_mask

  // ==========================================================================
  // Key pin synchroniser
  // ==========================================================================
  logic key_meta;
  logic key_sync;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      key_meta <= 1'b0;
      key_sync <= 1'b0;
    end else begin
      key_meta <= key_press;
      key_sync <= key_meta;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  typedef enum logic [2:0] {
    st_idle, st_wait_ops, st_opc, st_run_eng, st_run_key
  } state_type;

  state_type  state;
  logic [3:0] run_mask;
  logic       run_frame;
  logic       run_is_card;
  logic       run_selftest;

  wire       accept   = cmd_valid && cmd_ready;
  wire [3:0] sel_mask = card_mask(cmd_card);
  wire       sel_ok   = (sel_mask != 4'h0);
  wire       state_ok = (cmd_card != CARD_ALL) && sel_ok;
  wire       is_fp    = (cmd_frame == FRAME_FRONT_PANEL_SELFTEST);

  assign cmd_ready               = (state == st_idle);
  assign operation_complete_flag = !op_pending;

  // Results
  logic [1:0] card_res [NUM_CARDS];
  logic [1:0] frame_res [2];
  logic [3:0] card_clr;
  logic [3:0] card_wr;
  logic [1:0] frame_clr;
  logic [1:0] frame_wr;
  logic       key_done;
  logic       key_fail;

  wire eng_finish  = (state == st_run_eng) && test_done;
  wire key_start   = accept && cmd_code == cmd_frame_exec && is_fp;
  wire [3:0] any_f = test_card_fail & run_mask;

  assign card_clr = (accept && cmd_code == cmd_card_clear) ?
                    sel_mask : 4'h0;
  assign card_wr  = (eng_finish && run_is_card) ? run_mask : 4'h0;
  assign frame_clr[FRAME_CTRL]   = accept && cmd_code == cmd_frame_clear
                                   && !is_fp;
  assign frame_clr[FRAME_FRONT_PANEL_SELFTEST] = accept && cmd_code == cmd_frame_clear
                                   && is_fp;
  assign frame_wr[FRAME_CTRL]    = eng_finish && !run_is_card
                                   && !run_selftest
                                   && run_frame == FRAME_CTRL;
  assign frame_wr[FRAME_FRONT_PANEL_SELFTEST]  = key_done;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CARDS; gi++) begin : g_card
      selftest_result_store u_card (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .clear      (card_clr[gi]),
        .write      (card_wr[gi]),
        .write_fail (test_card_fail[gi]),
        .result     (card_res[gi])
      );
    end
    for (gi = 0; gi < 2; gi++) begin : g_frame
      selftest_result_store u_frame (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .clear      (frame_clr[gi]),
        .write      (frame_wr[gi]),
        .write_fail (gi == 1 ? key_fail : test_frame_fail),
        .result     (frame_res[gi])
      );
    end
  endgenerate

  selftest_key_timer #(
    .TIMEOUT_CYC (KEY_TIMEOUT)
  ) u_key (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (key_start),
    .key_seen (key_sync),
    .done     (key_done),
    .fail     (key_fail)
  );

  // Result value as a response byte, -1 as all ones
  function automatic logic [7:0] res_byte(input logic [1:0] r);
    return (r == RES_UNTESTED) ? 8'hff : {6'h0, r};
  endfunction : res_byte

  wire [1:0] card_pick  = 2'(cmd_card - 3'h1);
  wire [7:0] card_query = res_byte(card_res[card_pick]);
  wire [7:0] frame_query = res_byte(frame_res[cmd_frame]);

  // ==========================================================================
  // Sequencer state
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state        <= st_idle;
      run_mask     <= 4'h0;
      run_frame    <= 1'b0;
      run_is_card  <= 1'b0;
      run_selftest <= 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          if (accept) begin
            run_mask     <= sel_mask;
            run_frame    <= cmd_frame;
            run_is_card  <= (cmd_code == cmd_card_exec);
            run_selftest <= (cmd_code == cmd_selftest);
            if (cmd_code == cmd_wait)
              state <= st_wait_ops;
            else if (cmd_code == cmd_opc_query)
              state <= st_opc;
            else if (cmd_code == cmd_selftest)
              state <= st_run_eng;
            else if (cmd_code == cmd_card_exec && sel_ok)
              state <= st_run_eng;
            else if (cmd_code == cmd_frame_exec)
              state <= is_fp ? st_run_key : st_run_eng;
          end
        end
        st_wait_ops: if (operation_complete_flag) state <= st_idle;
        st_opc:      if (operation_complete_flag) state <= st_idle;
        st_run_eng:  if (test_done) state <= st_idle;
        st_run_key:  if (key_done) state <= st_idle;
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  wire eng_go = accept && (cmd_code == cmd_selftest
                || (cmd_code == cmd_card_exec && sel_ok)
                || (cmd_code == cmd_frame_exec && !is_fp));
  wire is_route = accept && (cmd_code == cmd_route_open
                  || cmd_code == cmd_route_close) && sel_ok;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rsp_valid              <= 1'b0;
      rsp_data               <= 8'h0;
      test_start             <= 1'b0;
      test_cards             <= 4'h0;
      test_frame             <= 1'b0;
      test_is_card           <= 1'b0;
      instrument_reset       <= 1'b0;
      power_on_card_settings <= 4'h0;
      relay_strobe           <= 1'b0;
      relay_card             <= 3'h0;
      relay_channel          <= 6'h0;
      relay_closed           <= 1'b0;
    end else begin
      rsp_valid              <= 1'b0;
      test_start             <= 1'b0;
      instrument_reset       <= 1'b0;
      power_on_card_settings <= 4'h0;
      relay_strobe           <= 1'b0;
      if (eng_go) begin
        test_start   <= 1'b1;
        test_cards   <= (cmd_code == cmd_card_exec) ? sel_mask : 4'h0;
        test_frame   <= cmd_frame;
        test_is_card <= (cmd_code == cmd_card_exec);
      end
      if (accept && cmd_code == cmd_card_state) begin
        rsp_valid <= 1'b1;
        rsp_data  <= state_ok ? card_query : 8'hff;
      end
      if (accept && cmd_code == cmd_frame_state) begin
        rsp_valid <= 1'b1;
        rsp_data  <= frame_query;
      end
      if (state == st_opc && operation_complete_flag) begin
        rsp_valid <= 1'b1;
        rsp_data  <= OPC_CHAR;
      end
      if (eng_finish) begin
        rsp_valid <= 1'b1;
        if (run_is_card) begin
          rsp_data <= {7'h0, |any_f};
          power_on_card_settings <= run_mask;
        end else begin
          rsp_data <= {7'h0, test_frame_fail};
          instrument_reset <= 1'b1;
        end
      end
      if (state == st_run_key && key_done) begin
        rsp_valid <= 1'b1;
        rsp_data  <= {7'h0, key_fail};
      end
      if (is_route) begin
        relay_strobe  <= 1'b1;
        relay_card    <= cmd_card;
        relay_channel <= cmd_channel;
        relay_closed  <= (cmd_code == cmd_route_close);
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_wait_holds : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state == st_wait_ops && op_pending |=> !cmd_ready)
    else $error("Command taken while operations pending");

  a_opc_char : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state == st_opc && !op_pending |=> rsp_valid && rsp_data == OPC_CHAR)
    else $error("Completion query answer wrong");

  a_opc_hold : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state == st_opc && op_pending |=> !rsp_valid)
    else $error("Completion answered while pending");

  a_card_reset : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    eng_finish && run_is_card |=> power_on_card_settings == $past(run_mask)
    && !instrument_reset)
    else $error("Tested card not given power-on settings");

  a_ctrl_reset : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    eng_finish && !run_is_card |=> instrument_reset && rsp_valid)
    else $error("Controller or self test missed reset");

  a_fp_nochange : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state == st_run_key |=> !instrument_reset
    && power_on_card_settings == 4'h0)
    else $error("Front panel test changed settings");

  a_key_answer : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    state == st_run_key && key_done
    |=> rsp_valid && rsp_data == {7'h0, $past(key_fail)})
    else $error("Front panel answer wrong");

  a_card_fail_any : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    eng_finish && run_is_card && (any_f != 4'h0) |=> rsp_data == 8'h01)
    else $error("Failing card not reported");

  a_bad_card : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    accept && cmd_code == cmd_card_exec && !sel_ok
    |=> !test_start && cmd_ready)
    else $error("Invalid card started a test");

  a_clear_all : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    accept && cmd_code == cmd_card_clear && cmd_card == CARD_ALL
    |-> card_clr == 4'hf)
    else $error("Clear of all cards incomplete");

  a_route_dir : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    is_route |=> relay_strobe
    && relay_closed == ($past(cmd_code) == cmd_route_close))
    else $error("Relay direction wrong");

  a_card_untested : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    accept && cmd_code == cmd_card_state && state_ok
    && card_res[card_pick] == RES_UNTESTED |=> rsp_data == 8'hff)
    else $error("Untested card not -1");

  a_frame_untested : assert property (
    @(posedge core_clk) disable iff (sys_rst)
    accept && cmd_code == cmd_frame_state
    && frame_res[cmd_frame] == RES_UNTESTED |=> rsp_data == 8'hff)
    else $error("Untested frame not -1");

endmodule : self_test_command_handler

// ==== tb/selftest_engine_model.sv ====
`timescale 1ns/1ps
module selftest_engine_model #(
  parameter int DELAY = 4
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Start and configured outcome
  input  wire logic       test_start,
  input  wire logic [3:0] card_fail_cfg,
  input  wire logic       frame_fail_cfg,
  // Result
  output logic            test_done,
  output logic [3:0]      test_card_fail,
  output logic            test_frame_fail
);
  // ==========================================================================
  // Test run delay
  // ==========================================================================
  int cnt;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt       <= 0;
      test_done <= 1'b0;
    end else begin
      test_done <= 1'b0;
      if (test_start) begin
        cnt <= DELAY;
      end else if (cnt == 1) begin
        cnt       <= 0;
        test_done <= 1'b1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end

  // Result lines carry junk outside the done pulse
  assign test_card_fail  = test_done ? card_fail_cfg : ~card_fail_cfg;
  assign test_frame_fail = test_done ? frame_fail_cfg : ~frame_fail_cfg;
endmodule : selftest_engine_model

// ==== tb/self_test_command_handler_bench.sv ====
`timescale 1ns/1ps
module self_test_command_handler_bench;
  import selftest_pkg::*;
  localparam int KT = 50;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        core_clk, sys_rst, cmd_valid, cmd_frame, op_pending, key_press;
  command_type cmd_code;
  logic [2:0]  cmd_card, relay_card;
  logic [5:0]  cmd_channel, relay_channel;
  logic        cmd_ready, rsp_valid, operation_complete_flag, test_start;
  logic        test_frame, test_is_card, test_done, test_frame_fail;
  logic        instrument_reset, relay_strobe, relay_closed, eng_frame;
  logic [7:0]  rsp_data;
  logic [3:0]  test_cards, test_card_fail, power_on_card_settings, eng_card;
  logic [7:0]  rsp_q[$];
  logic [3:0]  cap_cards, cap_pos;
  logic        cap_is_card, cap_frame;
  int          n_fail, check_count, n_start, n_ireset, n_strobe, last_wait;

  self_test_command_handler #(.KEY_TIMEOUT(KT)) uut (
    .core_clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_code, .cmd_card,
    .cmd_frame, .cmd_channel, .rsp_valid, .rsp_data, .op_pending,
    .operation_complete_flag, .test_start, .test_cards, .test_frame,
    .test_is_card, .test_done, .test_card_fail, .test_frame_fail,
    .key_press, .instrument_reset, .power_on_card_settings, .relay_strobe,
    .relay_card, .relay_channel, .relay_closed);

  selftest_engine_model #(.DELAY(4)) engine (
    .core_clk, .sys_rst, .test_start, .card_fail_cfg(eng_card),
    .frame_fail_cfg(eng_frame), .test_done, .test_card_fail,
    .test_frame_fail);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Output monitor
  // ==========================================================================
  always @(negedge core_clk) begin
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
    if (test_start === 1'b1) begin
      n_start++;
      cap_cards   = test_cards;
      cap_is_card = test_is_card;
      cap_frame   = test_frame;
    end
    if (power_on_card_settings !== 4'h0) cap_pos = power_on_card_settings;
    if (instrument_reset === 1'b1) n_ireset++;
    if (relay_strobe === 1'b1) n_strobe++;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic send(command_type c, logic [2:0] cd, logic fr,
                      logic [5:0] ch);
    int k;
    k = 0;
    @(negedge core_clk);
    cmd_code = c; cmd_card = cd; cmd_frame = fr; cmd_channel = ch;
    cmd_valid = 1'b1;
    #1;
    while (cmd_ready !== 1'b1 && k < 500) begin
      @(negedge core_clk);
      #1;
      k++;
    end
    chk(8'(k < 500), 8'h1, "command taken");
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask : send

  task automatic get_rsp(logic [7:0] exp, int maxw, string what);
    last_wait = 0;
    while (rsp_q.size() == 0 && last_wait < maxw) begin
      @(negedge core_clk);
      last_wait++;
    end
    if (rsp_q.size() == 0) chk(8'h0, 8'h1, {what, " missing"});
    else chk(rsp_q.pop_front(), exp, what);
  endtask : get_rsp

  task automatic query(command_type c, logic [2:0] cd, logic fr,
                       logic [7:0] exp);
    send(c, cd, fr, 6'h0);
    get_rsp(exp, 40, "query answer");
  endtask : query

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    chk({7'h0, cmd_ready}, 8'h1, "ready after reset");
    chk({4'h0, power_on_card_settings}, 8'h0, "idle settings");
    for (int c = 1; c <= 4; c++) query(cmd_card_state, 3'(c), 0, 8'hff);
    query(cmd_card_state, CARD_ALL, 0, 8'hff);
    query(cmd_frame_state, 0, FRAME_CTRL, 8'hff);
    query(cmd_frame_state, 0, FRAME_FRONT_PANEL_SELFTEST, 8'hff);
  endtask : t_reset

  task automatic t_selftest;
    int n0;
    for (int f = 0; f <= 1; f++) begin
      eng_frame = f[0];
      n0 = n_ireset;
      query(cmd_selftest, 0, 0, 8'(f));
      repeat (2) @(negedge core_clk);
      chk({7'h0, cap_is_card}, 8'h0, "engine mode");
      chk(8'(n_ireset - n0), 8'h1, "reset after self-test");
    end
  endtask : t_selftest

  task automatic t_cards;
    eng_card = 4'b1100;
    cap_pos  = 4'h0;
    query(cmd_card_exec, 3'h2, 0, 8'h0);
    chk({4'h0, cap_cards}, 8'h02, "tested mask");
    chk({4'h0, cap_pos}, 8'h02, "card settings");
    query(cmd_card_state, 3'h2, 0, 8'h0);
    query(cmd_card_state, 3'h3, 0, 8'hff);
    eng_card = 4'b0100;
    query(cmd_card_exec, CARD_ALL, 0, 8'h1);
    chk({4'h0, cap_cards}, 8'h0f, "all mask");
    chk({4'h0, cap_pos}, 8'h0f, "all settings");
    query(cmd_card_state, 3'h3, 0, 8'h1);
    send(cmd_card_clear, 3'h3, 0, 6'h0);
    query(cmd_card_state, 3'h3, 0, 8'hff);
    query(cmd_card_state, 3'h1, 0, 8'h0);
    send(cmd_card_clear, CARD_ALL, 0, 6'h0);
    query(cmd_card_state, 3'h1, 0, 8'hff);
  endtask : t_cards

  task automatic t_bad_card;
    int n0;
    n0 = n_start;
    send(cmd_card_exec, 3'h5, 0, 6'h0);
    repeat (20) @(negedge core_clk);
    chk(8'(rsp_q.size()), 8'h0, "no answer");
    chk(8'(n_start - n0), 8'h0, "no test run");
  endtask : t_bad_card

  task automatic t_frames;
    int n0;
    eng_frame = 1'b1;
    n0 = n_ireset;
    query(cmd_frame_exec, 0, FRAME_CTRL, 8'h1);
    repeat (2) @(negedge core_clk);
    chk(8'(n_ireset - n0), 8'h1, "reset after ctrl");
    chk({7'h0, cap_frame}, {7'h0, FRAME_CTRL}, "frame select");
    query(cmd_frame_state, 0, FRAME_CTRL, 8'h1);
    query(cmd_frame_state, 0, FRAME_FRONT_PANEL_SELFTEST, 8'hff);
    send(cmd_frame_clear, 0, FRAME_CTRL, 6'h0);
    query(cmd_frame_state, 0, FRAME_CTRL, 8'hff);
    n0 = n_ireset;
    send(cmd_frame_exec, 0, FRAME_FRONT_PANEL_SELFTEST, 6'h0);
    repeat (5) @(negedge core_clk);
    key_press = 1'b1;
    get_rsp(8'h0, 30, "key pass");
    key_press = 1'b0;
    query(cmd_frame_state, 0, FRAME_FRONT_PANEL_SELFTEST, 8'h0);
    send(cmd_frame_exec, 0, FRAME_FRONT_PANEL_SELFTEST, 6'h0);
    get_rsp(8'h1, KT + 20, "key timeout");
    chk(8'(last_wait >= KT - 3 && last_wait <= KT + 6), 8'h1, "timeout");
    chk(8'(n_ireset - n0), 8'h0, "panel keeps settings");
  endtask : t_frames

  task automatic t_wait_opc;
    int k;
    op_pending = 1'b1;
    send(cmd_wait, 0, 0, 6'h0);
    repeat (5) @(negedge core_clk);
    chk({7'h0, cmd_ready}, 8'h0, "held off");
    chk({7'h0, operation_complete_flag}, 8'h0, "flag low");
    op_pending = 1'b0;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 4) begin
      @(negedge core_clk);
      k++;
    end
    chk({7'h0, cmd_ready}, 8'h1, "released");
    op_pending = 1'b1;
    send(cmd_opc_query, 0, 0, 6'h0);
    repeat (8) @(negedge core_clk);
    chk(8'(rsp_q.size()), 8'h0, "no early char");
    op_pending = 1'b0;
    get_rsp(OPC_CHAR, 5, "completion char");
  endtask : t_wait_opc

  task automatic t_route;
    int n0;
    for (int i = 0; i < 2; i++) begin
      n0 = n_strobe;
      send(i ? cmd_route_open : cmd_route_close, 3'(3 + i), 0, 6'(42 - i));
      #1;
      chk(8'(n_strobe - n0), 8'h1, "relay strobe");
      chk({5'h0, relay_card}, 8'(3 + i), "relay card");
      chk({2'h0, relay_channel}, 8'(42 - i), "relay chan");
      chk({7'h0, relay_closed}, 8'(1 - i), "relay state");
    end
    n0 = n_strobe;
    send(cmd_route_close, 3'h7, 0, 6'h1);
    repeat (4) @(negedge core_clk);
    chk(8'(n_strobe - n0), 8'h0, "bad card route");
  endtask : t_route

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    sys_rst = 1'b1; cmd_valid = 1'b0; cmd_code = cmd_selftest;
    cmd_card = 3'h0; cmd_frame = 1'b0; cmd_channel = 6'h0;
    op_pending = 1'b0; key_press = 1'b0; eng_card = 4'h0;
    eng_frame = 1'b0; n_fail = 0; check_count = 0; n_start = 0;
    n_ireset = 0; n_strobe = 0; cap_pos = 4'h0;
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    t_reset();
    t_selftest();
    t_cards();
    t_bad_card();
    t_frames();
    t_wait_opc();
    t_route();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("mismatch t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : self_test_command_handler_bench
